// *** rtl/mas_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures of
 * the monitor sequencer. Assumes a single 100 MHz system clock.
 */
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// Register offsets
`define MAS_OFS_CFG 8'h00
`define MAS_OFS_FLAGS 8'h01
`define MAS_OFS_MASK 8'h03
`define MAS_OFS_PACE 8'h07
`define MAS_OFS_CHDIS 8'h08
`define MAS_OFS_TRIG 8'h09
`define MAS_OFS_REFMODE 8'h0B
`define MAS_OFS_BUSY 8'h0C
`define MAS_OFS_READ_LO 8'h20
`define MAS_OFS_READ_HI 8'h27
`define MAS_OFS_LIM_LO 8'h2A
`define MAS_OFS_LIM_HI 8'h39

// Field positions
`define MAS_CFG_START 0
`define MAS_CFG_INTEN 1
`define MAS_CFG_INTCLR 3
`define MAS_PACE_CONT 0
`define MAS_REF_EXT 0
`define MAS_MODE_HI 2
`define MAS_MODE_LO 1
`define MAS_BUSY_BIT 0

// Reset values
`define MAS_CFG_RST 8'h08

// Codes and slots
`define MAS_CODE_MAX 12'hFFF
`define MAS_LAST_SLOT 3'h7
`define MAS_TEMP_SLOT 3'h7

// Timing
`define MAS_CLK_MHZ 100
`define MAS_LP_PERIOD_MS 728

`endif

// *** rtl/mas_pkg.sv ***
/*
 * Types shared by the monitor sequencer files.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package mas_pkg;

   typedef enum logic [1:0] {
      MAS_IDLE = 2'b00,
      MAS_PICK = 2'b01,
      MAS_WAIT = 2'b10,
      MAS_GAP = 2'b11
   } mas_st_e;

   // What the front-end is asked to measure
   typedef struct packed {
      logic temp;
      logic diff;
      logic [2:0] pos;
      logic [2:0] neg;
   } mas_sel_s;

   typedef struct packed {
      logic valid;
      mas_sel_s sel;
   } mas_slot_s;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mas_req_s;

   typedef struct packed {
      mas_st_e st;
      logic [2:0] slot;
      logic [7:0] cfg;
      logic [7:0] flags;
      logic [7:0] mask;
      logic [7:0] pace;
      logic [7:0] chdis;
      logic [7:0] refmode;
      logic [7:0][15:0] reads;
      logic [15:0][7:0] lims;
      logic [31:0] tmr;
      logic trig_pend;
      logic req;
      mas_sel_s sel;
      logic [15:0] rdata;
      logic irq;
   } mas_state_s;

endpackage
`default_nettype wire

// *** rtl/mas_result_check.sv ***
/*
 * Turns one front-end sample into a reading word and checks a voltage against
 * its limit pair, a temperature against its high limit only. Purely combinational; the caller registers the outputs.
 */
`include "mas_regs.svh"
`default_nettype none
module mas_result_check #(
   parameter int RAW_W = 14
) (
   // Sample
   input wire logic is_temp,
   input wire logic signed [RAW_W-1:0] raw,
   input wire logic [8:0] temp,
   // Limits
   input wire logic [7:0] lim_hi,
   input wire logic [7:0] lim_lo,
   // Result
   output logic [15:0] code,
   output logic viol
);
   logic [11:0] vcode;

   always_comb begin
      if (raw < 0) begin
         vcode = 12'h000;
      end else if (raw > $signed({{(RAW_W-12){1'b0}}, `MAS_CODE_MAX})) begin
         vcode = `MAS_CODE_MAX;
      end else begin
         vcode = raw[11:0];
      end
      if (is_temp) begin
         code = {{7{temp[8]}}, temp};
         viol = $signed(temp) > $signed({lim_hi, 1'b0});
      end else begin
         code = {4'h0, vcode};
         viol = (vcode[11:4] > lim_hi) || (vcode[11:4] < lim_lo);
      end
   end
endmodule
`default_nettype wire

// *** rtl/mas_sequencer.sv ***
/*
 * Measurement sequencer, register file, limit checks and alert pin of an
 * eight-input monitor converter. Assumes a serial-bus slave outside that
 * presents single register reads and writes, and an analog front-end that
 * answers each conversion request with a done pulse and its sample.
 */
`include "mas_regs.svh"
`default_nettype none
// Summary of operation
// - Voltage inputs give 12-bit unsigned codes, 0.625 mV per step internally.
// - Temperature is a 9-bit two's complement word, 0.5 C per step.
// - After start, step through configured slots in fixed order, loop per pace.
// - Every voltage result is compared with its limit pair; temperature with its high limit only.
// - A limit violation sets the slot's bit in the event flags register.
// - Internal reference after reset; external only by writing reference register.
// - Input mode comes from bits 2:1 of the reference and mode register.
// - Four modes; mode 0 seven inputs plus temp, mode 1 eight, no temp.
// - Mode 2: 0-1, 3-2, 4-5, 7-6; mode 3: 0..3 then 4-5, 7-6.
// - At most eight single-ended or four differential channels per mode.
// - Voltage code equals input difference over reference times 4096.
// - Out-of-range inputs saturate at code 0 or 4095, never wrap.
// - Continuous, low-power and single-shot pacing are all offered.
// - Low-power converts all enabled slots once, idles, repeats each 728 ms.
// - Alert pin behaviour is set by software through the registers.
// - Bit 0 of the reference and mode register selects external reference.
// - Flags whose mask bit is set never drive the alert pin.
module mas_sequencer #(
   parameter int RAW_W = 14,
   parameter int unsigned LP_CYCLES = `MAS_LP_PERIOD_MS * 1000 * `MAS_CLK_MHZ
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // Register port
   input wire mas_pkg::mas_req_s reg_req,
   output logic [15:0] reg_rdata,
   // Front-end
   output logic conv_req,
   output mas_pkg::mas_sel_s conv_sel,
   output logic ref_ext,
   input wire logic conv_done,
   input wire logic signed [RAW_W-1:0] conv_raw,
   input wire logic [8:0] conv_temp,
   // Alert pin and busy flag
   output logic alert_n,
   output logic busy
);
   mas_pkg::mas_state_s q, d;
   logic [15:0] chk_code;
   logic chk_viol;
   logic [7:0] flag_set, flag_clr;
   logic [1:0] mode;
   logic pass_end;
   mas_pkg::mas_slot_s cur;

   function automatic mas_pkg::mas_slot_s map_slot(input logic [1:0] m, input logic [2:0] s);
      mas_pkg::mas_slot_s r;
      r = '0;
      unique case (m)
         2'b00: begin
            r.valid = 1'b1;
            r.sel.temp = (s == `MAS_TEMP_SLOT);
            r.sel.pos = s;
         end
         2'b01: begin
            r.valid = 1'b1;
            r.sel.pos = s;
         end
         2'b10: begin
            r.valid = (s < 3'h4) || (s == `MAS_TEMP_SLOT);
            r.sel.temp = (s == `MAS_TEMP_SLOT);
            r.sel.diff = (s < 3'h4);
            unique case (s[1:0])
               2'b00: begin r.sel.pos = 3'h0; r.sel.neg = 3'h1; end
               2'b01: begin r.sel.pos = 3'h3; r.sel.neg = 3'h2; end
               2'b10: begin r.sel.pos = 3'h4; r.sel.neg = 3'h5; end
               2'b11: begin r.sel.pos = 3'h7; r.sel.neg = 3'h6; end
            endcase
            if (!r.sel.diff) begin
               r.sel.pos = 3'h0;
               r.sel.neg = 3'h0;
            end
         end
         2'b11: begin
            r.valid = (s != 3'h6);
            r.sel.temp = (s == `MAS_TEMP_SLOT);
            r.sel.diff = (s == 3'h4) || (s == 3'h5);
            r.sel.pos = (s == 3'h5) ? 3'h7 : ((s < 3'h5) ? s : 3'h0);
            r.sel.neg = (s == 3'h4) ? 3'h5 : ((s == 3'h5) ? 3'h6 : 3'h0);
         end
      endcase
      if (r.sel.temp) begin
         r.sel.pos = 3'h0;
      end
      return r;
   endfunction

   mas_result_check #(
      .RAW_W(RAW_W)
   ) u_check (
      .is_temp(q.sel.temp),
      .raw(conv_raw),
      .temp(conv_temp),
      .lim_hi(q.lims[{q.slot, 1'b0}]),
      .lim_lo(q.lims[{q.slot, 1'b1}]),
      .code(chk_code),
      .viol(chk_viol)
   );

   always_comb begin
      d = q;
      d.req = 1'b0;
      mode = q.refmode[`MAS_MODE_HI:`MAS_MODE_LO];
      cur = map_slot(mode, q.slot);
      flag_set = 8'h00;
      flag_clr = 8'h00;
      pass_end = 1'b0;
      if (q.st != mas_pkg::MAS_IDLE) begin
         d.tmr = q.tmr + 32'h1;
      end

      // Register writes
      if (reg_req.wr) begin
         if (reg_req.addr == `MAS_OFS_CFG) begin
            d.cfg = reg_req.wdata;
         end
         if (reg_req.addr == `MAS_OFS_MASK) begin
            d.mask = reg_req.wdata;
         end
         if (reg_req.addr == `MAS_OFS_PACE) begin
            d.pace = reg_req.wdata;
         end
         if (reg_req.addr == `MAS_OFS_CHDIS) begin
            d.chdis = reg_req.wdata;
         end
         if (reg_req.addr == `MAS_OFS_TRIG && !q.cfg[`MAS_CFG_START]) begin
            d.trig_pend = 1'b1;
         end
         if (reg_req.addr == `MAS_OFS_REFMODE) begin
            d.refmode = reg_req.wdata;
         end
         if (reg_req.addr >= `MAS_OFS_LIM_LO && reg_req.addr <= `MAS_OFS_LIM_HI) begin
            d.lims[4'(reg_req.addr - `MAS_OFS_LIM_LO)] = reg_req.wdata;
         end
      end

      // Register reads, one cycle latency
      if (reg_req.rd) begin
         d.rdata = 16'h0000;
         if (reg_req.addr == `MAS_OFS_CFG) begin
            d.rdata = {8'h00, q.cfg};
         end
         if (reg_req.addr == `MAS_OFS_FLAGS) begin
            d.rdata = {8'h00, q.flags};
            flag_clr = q.flags;
         end
         if (reg_req.addr == `MAS_OFS_MASK) begin
            d.rdata = {8'h00, q.mask};
         end
         if (reg_req.addr == `MAS_OFS_PACE) begin
            d.rdata = {8'h00, q.pace};
         end
         if (reg_req.addr == `MAS_OFS_CHDIS) begin
            d.rdata = {8'h00, q.chdis};
         end
         if (reg_req.addr == `MAS_OFS_REFMODE) begin
            d.rdata = {8'h00, q.refmode};
         end
         if (reg_req.addr == `MAS_OFS_BUSY) begin
            d.rdata[`MAS_BUSY_BIT] = (q.st != mas_pkg::MAS_IDLE);
         end
         if (reg_req.addr >= `MAS_OFS_READ_LO && reg_req.addr <= `MAS_OFS_READ_HI) begin
            d.rdata = q.reads[reg_req.addr[2:0]];
         end
         if (reg_req.addr >= `MAS_OFS_LIM_LO && reg_req.addr <= `MAS_OFS_LIM_HI) begin
            d.rdata = {8'h00, q.lims[4'(reg_req.addr - `MAS_OFS_LIM_LO)]};
         end
      end

      unique case (q.st)
         mas_pkg::MAS_IDLE: begin
            if (q.cfg[`MAS_CFG_START] || q.trig_pend) begin
               d.trig_pend = 1'b0;
               d.slot = 3'h0;
               d.tmr = 32'h0;
               d.st = mas_pkg::MAS_PICK;
            end
         end
         mas_pkg::MAS_PICK: begin
            if (cur.valid && !q.chdis[q.slot]) begin
               d.req = 1'b1;
               d.sel = cur.sel;
               d.st = mas_pkg::MAS_WAIT;
            end else if (q.slot == `MAS_LAST_SLOT) begin
               pass_end = 1'b1;
            end else begin
               d.slot = q.slot + 3'h1;
            end
         end
         mas_pkg::MAS_WAIT: begin
            if (conv_done) begin
               d.reads[q.slot] = chk_code;
               flag_set[q.slot] = chk_viol;
               if (q.slot == `MAS_LAST_SLOT) begin
                  pass_end = 1'b1;
               end else begin
                  d.slot = q.slot + 3'h1;
                  d.st = mas_pkg::MAS_PICK;
               end
            end
         end
         mas_pkg::MAS_GAP: begin
            if (!q.cfg[`MAS_CFG_START]) begin
               d.st = mas_pkg::MAS_IDLE;
            end else if (q.tmr >= 32'(LP_CYCLES - 1)) begin
               d.tmr = 32'h0;
               d.slot = 3'h0;
               d.st = mas_pkg::MAS_PICK;
            end
         end
      endcase

      if (pass_end) begin
         d.slot = 3'h0;
         if (!q.cfg[`MAS_CFG_START]) begin
            d.st = mas_pkg::MAS_IDLE;
         end else if (q.pace[`MAS_PACE_CONT]) begin
            d.tmr = 32'h0;
            d.st = mas_pkg::MAS_PICK;
         end else begin
            d.st = mas_pkg::MAS_GAP;
         end
      end

      // Set wins over read-clear
      d.flags = (q.flags & ~flag_clr) | flag_set;
      // enable and clear bits steer the pin
      // masked flags held off the pin
      d.irq = d.cfg[`MAS_CFG_INTEN] && !d.cfg[`MAS_CFG_INTCLR] && |(d.flags & ~d.mask);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q <= '0;
         q.refmode <= 8'h00;
         q.cfg <= `MAS_CFG_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign conv_req = q.req;
   assign conv_sel = q.sel;
   assign ref_ext = q.refmode[`MAS_REF_EXT];
   assign alert_n = !q.irq;
   assign busy = (q.st != mas_pkg::MAS_IDLE);

   chk_sat_low: assert property (@(posedge clk_sys) disable iff (srst)
      ce && q.st == mas_pkg::MAS_WAIT && conv_done && !q.sel.temp && conv_raw < 0
      |=> q.reads[$past(q.slot)] == 16'h0000)
      else $error("negative input did not clamp to zero");

   chk_sat_high: assert property (@(posedge clk_sys) disable iff (srst)
      ce && q.st == mas_pkg::MAS_WAIT && conv_done && !q.sel.temp
      && conv_raw > $signed(RAW_W'(`MAS_CODE_MAX))
      |=> q.reads[$past(q.slot)] == 16'h0FFF)
      else $error("large input did not clamp to full scale");

   chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (srst)
      ce && !(reg_req.rd && reg_req.addr == `MAS_OFS_FLAGS)
      |=> (q.flags & $past(q.flags)) == $past(q.flags))
      else $error("event flag dropped without a read");

   chk_flag_set: assert property (@(posedge clk_sys) disable iff (srst)
      ce && q.st == mas_pkg::MAS_WAIT && conv_done && chk_viol
      |=> q.flags[$past(q.slot)])
      else $error("violation did not set its flag");

   chk_alert_mask: assert property (@(posedge clk_sys) disable iff (srst)
      !alert_n |-> (q.flags & ~q.mask) != 8'h00 && q.cfg[`MAS_CFG_INTEN])
      else $error("alert pin driven by masked or disabled flags");

   chk_ref_reset: assert property (@(posedge clk_sys)
      srst |=> !ref_ext)
      else $error("external reference selected after reset");

   chk_mode1_temp: assert property (@(posedge clk_sys) disable iff (srst)
      conv_req && mode == 2'b01 |-> !conv_sel.temp && !conv_sel.diff)
      else $error("mode 1 asked for temperature or a pair");

   chk_mode2_pair: assert property (@(posedge clk_sys) disable iff (srst)
      conv_req && mode == 2'b10 && q.slot == 3'h1
      |-> conv_sel.diff && conv_sel.pos == 3'h3 && conv_sel.neg == 3'h2)
      else $error("mode 2 second pair not 3 minus 2");

   chk_skip_disabled: assert property (@(posedge clk_sys) disable iff (srst)
      conv_req |-> !q.chdis[q.slot] && q.st == mas_pkg::MAS_WAIT)
      else $error("disabled slot was converted");

   chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (srst)
      ce && q.st == mas_pkg::MAS_IDLE && !q.cfg[`MAS_CFG_START] && !q.trig_pend
      |=> !conv_req [*2])
      else $error("conversion requested while stopped");
endmodule
`default_nettype wire

// *** test/mas_front_model.sv ***
/*
 * Analog front-end stand-in: answers each conversion request with a done
 * pulse and the selected input difference or the temperature word.
 * Assumes one outstanding request and a one-cycle request pulse.
 */
`default_nettype none
module mas_front_model #(
   parameter int RAW_W = 14
) (
   // Clock
   input wire logic clk_sys,
   // Sequencer side
   input wire logic conv_req,
   input wire mas_pkg::mas_sel_s conv_sel,
   output logic conv_done,
   output logic signed [RAW_W-1:0] conv_raw,
   output logic [8:0] conv_temp,
   // Bench side
   input wire logic slow,
   input wire logic [7:0][RAW_W-1:0] lvl,
   input wire logic [8:0] temp_val
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      conv_done = 1'b0;
      conv_raw = '0;
      conv_temp = 9'h000;
   end
   always @(posedge clk_sys) begin
      conv_done <= 1'b0;
      if (conv_req) begin
         cnt <= slow ? 6 : 1;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_raw <= $signed(lvl[conv_sel.pos]) - $signed(conv_sel.diff ? lvl[conv_sel.neg] : '0);
         conv_temp <= temp_val;
      end else begin
         // With no request pending the lines change, so stale data cannot pass
         conv_raw <= ~conv_raw;
         conv_temp <= ~conv_temp;
      end
   end
endmodule
`default_nettype wire

// *** test/mas_sequencer_bench.sv ***
/*
 * Self-checking bench of the monitor sequencer: register port tasks,
 * sequence capture per mode, readings, limits, alert and pacing.
 * Assumes the front-end model beside it and a shortened low-power period.
 */
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module mas_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Short low-power period keeps the run small
   localparam int LP = 200;
   logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, slow = 1'b0;
   mas_pkg::mas_req_s reg_req = '0;
   mas_pkg::mas_sel_s conv_sel;
   logic [15:0] reg_rdata;
   logic conv_req, ref_ext, conv_done, alert_n, busy;
   logic signed [13:0] conv_raw;
   logic [8:0] conv_temp;
   logic [7:0][13:0] lvl = {14'h0800, 14'h0001, 14'h1000, 14'h04D2,
      14'h0000, 14'h0FFF, 14'h1388, 14'h3FFB};
   logic [7:0] tbl[4][8] = '{'{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h80},
      '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38},
      '{8'h41, 8'h5A, 8'h65, 8'h7E, 8'h80, 8'h00, 8'h00, 8'h00},
      '{8'h00, 8'h08, 8'h10, 8'h18, 8'h65, 8'h7E, 8'h80, 8'h00}};
   int len[4] = '{8, 8, 5, 7};
   logic [15:0] rexp[8] = '{16'h0000, 16'h0FFF, 16'h0FFF, 16'h0000,
      16'h04D2, 16'h0FFF, 16'h0001, 16'h0800};
   int error_cnt = 0, checks_done = 0, cyc = 0;
   logic [7:0] seen[$];
   int t0[$];
   logic [7:0] mk;

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (conv_req) begin
         seen.push_back(conv_sel);
         if (conv_sel == 8'h00) begin
            t0.push_back(cyc);
         end
      end
   end

   mas_sequencer #(.RAW_W(14), .LP_CYCLES(LP)) uut (
      .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .conv_req(conv_req), .conv_sel(conv_sel), .ref_ext(ref_ext), .conv_done(conv_done),
      .conv_raw(conv_raw), .conv_temp(conv_temp), .alert_n(alert_n), .busy(busy));

   mas_front_model #(.RAW_W(14)) fe (
      .clk_sys(clk_sys), .conv_req(conv_req), .conv_sel(conv_sel), .conv_done(conv_done),
      .conv_raw(conv_raw), .conv_temp(conv_temp), .slow(slow), .lvl(lvl),
      .temp_val(9'h1FD));

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
      // Let the write settle before anyone looks
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   task automatic pass();
      int n;
      n = 0;
      wr(8'h09, 8'h01);
      while (busy !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (busy !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t: pass never started", $time);
         end_sim();
      end
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 3000) begin
         error_cnt++;
         $display("ERROR %0t: pass hung", $time);
         end_sim();
      end
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      rd(8'h00, 16'h0008);
      rd(8'h3C, 16'h0000);
      wr(8'h01, 8'hFF);
      rd(8'h01, 16'h0000);
      `CHK(ref_ext, 1'b0)
      wr(8'h0B, 8'h01);
      `CHK(ref_ext, 1'b1)
      rd(8'h0B, 16'h0001);
      // Frozen block ignores a write
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'h07, 8'h55);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd(8'h07, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         slow <= m[1];
         wr(8'h0B, 8'(m << 1));
         seen.delete();
         pass();
         `CHK(seen.size(), len[m])
         for (int i = 0; i < len[m]; i++) begin
            mk = tbl[m][i][7] ? 8'h80 : (tbl[m][i][6] ? 8'hFF : 8'hF8);
            `CHK(seen[i] & mk, tbl[m][i])
         end
         if (m == 0) rd(8'h27, 16'hFFFD);
         if (m == 1) for (int i = 0; i < 8; i++) rd(8'(8'h20 + i), rexp[i]);
         if (m == 2) rd(8'h23, 16'h07FF);
      end
      rd(8'h01, 16'h00BE);
      rd(8'h01, 16'h0000);
      for (int i = 0; i < 16; i++) wr(8'(8'h2A + i), i[0] ? 8'h00 : 8'hFF);
      wr(8'h32, 8'h10);
      wr(8'h2B, 8'h01);
      rd(8'h32, 16'h0010);
      wr(8'h00, 8'h02);
      wr(8'h0B, 8'h02);
      pass();
      `CHK(alert_n, 1'b0)
      wr(8'h03, 8'h11);
      @(posedge clk_sys);
      `CHK(alert_n, 1'b1)
      wr(8'h03, 8'h00);
      wr(8'h32, 8'hFF);
      wr(8'h2B, 8'h00);
      pass();
      rd(8'h01, 16'h0011);
      @(posedge clk_sys);
      `CHK(alert_n, 1'b1)
      // Slot 1 off, temperature high limit just under the sensor
      wr(8'h08, 8'h02);
      wr(8'h0B, 8'h04);
      wr(8'h38, 8'hFE);
      seen.delete();
      pass();
      `CHK(seen.size(), 4)
      `CHK(seen[1], 8'h65)
      rd(8'h01, 16'h0080);
      wr(8'h08, 8'h00);
      wr(8'h0B, 8'h02);
      wr(8'h00, 8'h01);
      t0.delete();
      repeat (3 * LP) @(posedge clk_sys);
      `CHK(t0.size() >= 3 && t0[2] - t0[1] >= LP && t0[2] - t0[1] <= LP + 2, 1'b1)
      wr(8'h07, 8'h01);
      rd(8'h07, 16'h0001);
      t0.delete();
      // Room for at least three back-to-back passes
      repeat (2 * LP) @(posedge clk_sys);
      `CHK(t0.size() >= 3 && t0[2] - t0[1] < LP, 1'b1)
      rd(8'h0C, 16'h0001);
      wr(8'h00, 8'h00);
      repeat (100) @(posedge clk_sys);
      `CHK(busy, 1'b0)
      // Reset again with the external reference selected
      wr(8'h0B, 8'h01);
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      `CHK(ref_ext, 1'b0)
      rd(8'h0B, 16'h0000);
      end_sim();
   end
endmodule
`default_nettype wire
